// ### ufef_map.vh
// register map, field positions and reset values of the usb event flag block
// assumes an avalon-mm slave with word-aligned registers (byte address = 4 x index)
`ifndef UFEF_MAP_VH
`define UFEF_MAP_VH

// register indices as printed; byte address is four times the index
`define UFEF_IDX_CTRL 8'h00
`define UFEF_IDX_SLEEP_CTRL 8'h01
`define UFEF_IDX_IN_FLAGS 8'h02
`define UFEF_IDX_OUT_FLAGS 8'h04
`define UFEF_IDX_BUS_FLAGS 8'h06
`define UFEF_IDX_IN_EN 8'h07
`define UFEF_IDX_OUT_EN 8'h09
`define UFEF_IDX_BUS_EN 8'h0B
`define UFEF_IDX_FRAME_LO 8'h0C
`define UFEF_IDX_FRAME_HI 8'h0D

// field positions
`define UFEF_IN_CTRL_BIT 0
`define UFEF_IN_EP1_BIT 1
`define UFEF_OUT_EP1_BIT 1
`define UFEF_BUS_SOF_BIT 3
`define UFEF_BUS_RST_BIT 2
`define UFEF_BUS_WAKE_BIT 1
`define UFEF_BUS_SLEEP_BIT 0
`define UFEF_SLEEP_ON_BIT 0
`define UFEF_SLEEP_STATE_BIT 1

// valid-bit masks; all other positions read zero
`define UFEF_IN_MASK 8'h03
`define UFEF_OUT_MASK 8'h02
`define UFEF_BUS_MASK 8'h0F
`define UFEF_CTRL_MASK 8'h01

// reset values
`define UFEF_RST_FLAGS 8'h00
// frame capture holds all eleven frame number bits
`define UFEF_RST_FRAME 11'h000
`define UFEF_RST_IN_EN 8'h03
`define UFEF_RST_OUT_EN 8'h02
`define UFEF_RST_BUS_EN 8'h06
`define UFEF_RST_CTRL 8'h00

`endif

// ### ufef_sync.v
// three-flop synchroniser bank for the bus event level inputs
// assumes inputs come from an unrelated domain; a change counts when stages two and three agree
`timescale 1ns/1ps
module ufef_sync #(
  parameter W = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] rise_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;

  // shift chain; s1 feeds only s2
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      lvl_q <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q)); // change only when both agree
    end
  end

  // one pulse on each accepted rising level
  assign rise_out = (s2_q & s3_q) & ~lvl_q;
endmodule // ufef_sync

// ### ufef_flags.v
// usb function event flag registers with clear-on-read and one aggregate request
// assumes avalon-mm master on mclk; sie event strobes are mclk-synchronous pulses
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ufef_map.vh"
module ufef_flags (
  input wire mclk,
  input wire sys_rst,
  // avalon-mm slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  // serial engine events, one-cycle mclk pulses
  input wire ctrl_rx_done,
  input wire ctrl_tx_done,
  input wire ep1_in_done,
  input wire ep1_out_done,
  input wire pkt_error,
  input wire sof_token,
  input wire sof_missed,
  input wire [10:0] frame_number,
  // bus line conditions from the transceiver, asynchronous levels
  input wire bus_reset_sig,
  input wire bus_resume_sig,
  input wire bus_suspend_sig,
  // outputs
  output wire usb_irq,
  output wire sleeping
);
  // handshake states of the register bus slave
  localparam HS_IDLE = 1'b0;
  localparam HS_ANSWER = 1'b1;
  // link power states
  localparam LINK_AWAKE = 1'b0;
  localparam LINK_ASLEEP = 1'b1;

  // registers of the map and the two small state machines
  reg [7:0] in_flags_q;
  reg [7:0] out_flags_q;
  reg [7:0] bus_flags_q;
  reg [7:0] in_en_q;
  reg [7:0] out_en_q;
  reg [7:0] bus_en_q;
  reg [7:0] ctrl_q;
  reg [10:0] frame_q;
  reg sleep_q;
  reg sleep_d;
  reg ack_q;
  reg ack_d;
  // combinational set terms and read selection
  reg [7:0] in_set;
  reg [7:0] out_set;
  reg [7:0] bus_set;
  reg [7:0] rd_mux;
  reg rd_err;
  // bus decode
  wire [7:0] idx;
  wire req;
  wire rd_go;
  wire wr_go;
  wire [2:0] line_rise;
  wire [7:0] wdat;
  // per-register strobes of the answering cycle
  wire wr_ctrl;
  wire wr_in_en;
  wire wr_out_en;
  wire wr_bus_en;
  wire clr_in;
  wire clr_out;
  wire clr_bus;
  // link power and request terms
  wire go_sleep;
  wire go_wake;
  wire in_req;
  wire out_req;
  wire bus_req;

  // masked flag update with read clear; shared by all three registers
  function [7:0] next_flags;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] mask;
    input clr;
    begin
      next_flags = ((clr ? 8'h00 : cur) | set) & mask; // set wins over read clear
    end
  endfunction

  // register select: current word index equals one map entry
  function reg_hit;
    input [7:0] cur_idx;
    input [7:0] map_idx;
    begin
      reg_hit = (cur_idx == map_idx);
    end
  endfunction

  // any flag of one register whose enable is on
  function flag_req;
    input [7:0] flags;
    input [7:0] en;
    begin
      flag_req = |(flags & en);
    end
  endfunction

  // bus line synchroniser: reset, resume, suspend
  ufef_sync #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({bus_reset_sig, bus_resume_sig, bus_suspend_sig}),
    .rise_out(line_rise)
  );

  // avalon decode: one wait cycle, answered on the following edge
  assign idx = {2'b00, avs_address};
  assign wdat = avs_writedata[7:0];
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & (ack_q == HS_IDLE);
  assign rd_go = avs_read & (ack_q == HS_ANSWER);
  assign wr_go = avs_write & (ack_q == HS_ANSWER);

  // strobes; flag and frame registers have none, so writes there are dropped
  assign wr_ctrl = wr_go & reg_hit(idx, `UFEF_IDX_CTRL);
  assign wr_in_en = wr_go & reg_hit(idx, `UFEF_IDX_IN_EN);
  assign wr_out_en = wr_go & reg_hit(idx, `UFEF_IDX_OUT_EN);
  assign wr_bus_en = wr_go & reg_hit(idx, `UFEF_IDX_BUS_EN);
  assign clr_in = rd_go & reg_hit(idx, `UFEF_IDX_IN_FLAGS);
  assign clr_out = rd_go & reg_hit(idx, `UFEF_IDX_OUT_FLAGS);
  assign clr_bus = rd_go & reg_hit(idx, `UFEF_IDX_BUS_FLAGS);

  // handshake: answer in the cycle after the request is first seen
  always @* begin
    ack_d = HS_IDLE;
    case (ack_q)
      HS_IDLE: ack_d = req ? HS_ANSWER : HS_IDLE;
      HS_ANSWER: ack_d = HS_IDLE;
      default: ack_d = HS_IDLE;
    endcase
  end

  // event set terms
  always @* begin
    in_set = 8'h00;
    out_set = 8'h00;
    bus_set = 8'h00;
    in_set[`UFEF_IN_CTRL_BIT] = (ctrl_rx_done | ctrl_tx_done) & ~pkt_error;
    in_set[`UFEF_IN_EP1_BIT] = ep1_in_done & ~pkt_error;
    out_set[`UFEF_OUT_EP1_BIT] = ep1_out_done & ~pkt_error;
    bus_set[`UFEF_BUS_SOF_BIT] = sof_token | sof_missed;
    bus_set[`UFEF_BUS_RST_BIT] = line_rise[2];
    bus_set[`UFEF_BUS_WAKE_BIT] = line_rise[1] & sleep_q;
    bus_set[`UFEF_BUS_SLEEP_BIT] = line_rise[0] & ctrl_q[`UFEF_SLEEP_ON_BIT];
  end

  // flag registers, clear-on-read per register
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      in_flags_q <= `UFEF_RST_FLAGS;
      out_flags_q <= `UFEF_RST_FLAGS;
      bus_flags_q <= `UFEF_RST_FLAGS;
    end else begin
      in_flags_q <= next_flags(in_flags_q, in_set, `UFEF_IN_MASK,
        clr_in);
      out_flags_q <= next_flags(out_flags_q, out_set, `UFEF_OUT_MASK,
        clr_out);
      bus_flags_q <= next_flags(bus_flags_q, bus_set, `UFEF_BUS_MASK,
        clr_bus);
    end
  end

  // interrupt enables; unused positions never store a one
  // a disabled flag still latches, it only stays out of the request
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      in_en_q <= `UFEF_RST_IN_EN;
      out_en_q <= `UFEF_RST_OUT_EN;
      bus_en_q <= `UFEF_RST_BUS_EN;
    end else begin
      if (wr_in_en) begin
        in_en_q <= wdat & `UFEF_IN_MASK;
      end
      if (wr_out_en) begin
        out_en_q <= wdat & `UFEF_OUT_MASK;
      end
      if (wr_bus_en) begin
        bus_en_q <= wdat & `UFEF_BUS_MASK;
      end
    end
  end

  // control register: sleep detection enable only
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= `UFEF_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= wdat & `UFEF_CTRL_MASK;
    end
  end

  // frame number of the latest start-of-frame token
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_q <= `UFEF_RST_FRAME;
    end else if (sof_token) begin
      frame_q <= frame_number;
    end
  end

  // bus handshake state
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= HS_IDLE;
    end else begin
      ack_q <= ack_d;
    end
  end

  // link power: suspend needs detection on; resume or bus reset wakes
  assign go_sleep = line_rise[0] & ctrl_q[`UFEF_SLEEP_ON_BIT];
  assign go_wake = line_rise[1] | line_rise[2];

  // resume wins over a suspend seen in the same cycle
  always @* begin
    sleep_d = sleep_q;
    case (sleep_q)
      LINK_AWAKE: begin
        if (go_sleep && !go_wake) begin
          sleep_d = LINK_ASLEEP;
        end
      end
      LINK_ASLEEP: begin
        if (go_wake) begin
          sleep_d = LINK_AWAKE;
        end
      end
      default: begin
        sleep_d = LINK_AWAKE;
      end
    endcase
  end

  // link power state register
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_q <= LINK_AWAKE;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  // per-register requests, then the single aggregate request
  assign in_req = flag_req(in_flags_q, in_en_q);
  assign out_req = flag_req(out_flags_q, out_en_q);
  assign bus_req = flag_req(bus_flags_q, bus_en_q);
  assign usb_irq = in_req | out_req | bus_req;
  assign sleeping = sleep_q;

  // read selection; flag reads include this cycle's events so none are lost
  always @* begin
    rd_mux = 8'h00;
    rd_err = 1'b0;
    case (idx)
      `UFEF_IDX_CTRL: rd_mux = ctrl_q;
      `UFEF_IDX_SLEEP_CTRL: rd_mux = {6'h00, sleep_q, ctrl_q[0]};
      `UFEF_IDX_IN_FLAGS: rd_mux = in_flags_q | in_set;
      `UFEF_IDX_OUT_FLAGS: rd_mux = out_flags_q | out_set;
      `UFEF_IDX_BUS_FLAGS: rd_mux = bus_flags_q | bus_set;
      `UFEF_IDX_IN_EN: rd_mux = in_en_q;
      `UFEF_IDX_OUT_EN: rd_mux = out_en_q;
      `UFEF_IDX_BUS_EN: rd_mux = bus_en_q;
      `UFEF_IDX_FRAME_LO: rd_mux = frame_q[7:0];
      `UFEF_IDX_FRAME_HI: rd_mux = {5'h00, frame_q[10:8]};
      default: rd_err = 1'b1; // unmapped: slave error, data zero
    endcase
  end

  // read data and response registered at the edge that opens the answer cycle
  // they stand unchanged until the next request is first seen
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if (req && ack_q == HS_IDLE) begin
      avs_readdata <= {24'h000000, rd_mux};
      avs_response <= rd_err ? 2'h2 : 2'h0;
    end
  end
endmodule // ufef_flags

// ### ufef_host.sv
// host-side model driving the bus line conditions (reset, resume, suspend)
// assumes the bench calls sig() from its main sequence; idle lines rest low
`timescale 1ns/1ps
module ufef_host (
  input wire logic mclk,
  output logic [2:0] line_q
);
  initial line_q = 3'h0;
  // hold one line condition for ten cycles, then leave the bus idle
  task sig(input int k);
    @(posedge mclk);
    line_q[k] <= 1'b1;
    repeat (10) @(posedge mclk);
    line_q[k] <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule // ufef_host

// ### ufef_flags_properties.sv
// concurrent checks on the ports of the event flag block
// assumes a single mclk domain with sys_rst active high
`timescale 1ns/1ps
module ufef_chk (
  input wire mclk,
  input wire sys_rst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire ctrl_rx_done,
  input wire ep1_in_done,
  input wire ep1_out_done,
  input wire pkt_error,
  input wire bus_resume_sig,
  input wire usb_irq,
  input wire sleeping
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // a read completing in this cycle
  wire done_rd = avs_read && !avs_waitrequest;
  wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read not stalled");
  wait_two_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("stall too long");
  in_unused_a: assert property (done_rd && avs_address == 6'h02 |-> avs_readdata[31:2] == 30'h0)
    else $error("in flags unused bits set");
  out_unused_a: assert property (done_rd && avs_address == 6'h04 |-> (avs_readdata & 32'hFFFFFFFD) == 32'h0)
    else $error("out flags unused bits set");
  bus_unused_a: assert property (done_rd && avs_address == 6'h06 |-> avs_readdata[31:4] == 28'h0)
    else $error("bus flags unused bits set");
  frame_unused_a: assert property (done_rd && avs_address == 6'h0D |-> avs_readdata[31:3] == 29'h0)
    else $error("frame upper unused bits set");
  unmapped_read_a: assert property (done_rd && avs_address == 6'h05 |-> avs_readdata == 32'h0 && avs_response == 2'h2)
    else $error("unmapped read wrong");
  ep_irq_a: assert property ((ctrl_rx_done || ep1_in_done || ep1_out_done) && !pkt_error |=> usb_irq)
    else $error("endpoint event gave no request");
  wake_exit_a: assert property (sleeping && $rose(bus_resume_sig) |-> ##[2:8] !sleeping)
    else $error("resume did not end sleep");
  cover property (done_rd && avs_address == 6'h06);
  cover property ($rose(usb_irq));
  cover property ($fell(sleeping));
endmodule // ufef_chk
bind ufef_flags ufef_chk ufef_chk_i (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response),
  .ctrl_rx_done(ctrl_rx_done),
  .ep1_in_done(ep1_in_done),
  .ep1_out_done(ep1_out_done),
  .pkt_error(pkt_error),
  .bus_resume_sig(bus_resume_sig),
  .usb_irq(usb_irq),
  .sleeping(sleeping)
);

// ### usb_function_event_flags_bench.sv
// self-checking bench for the usb event flag block
// assumes ufef_flags, ufef_host and the checker are compiled first
`timescale 1ns/1ps
module usb_function_event_flags_bench;
  logic mclk = 0, sys_rst = 1, rd = 0, wr = 0, irq, slp, wt;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rdat, got;
  logic [1:0] resp, gresp;
  logic [6:0] ev = 7'h00;
  logic [10:0] fn = 11'h000;
  logic [2:0] line;
  logic [7:0] v;
  logic ext_irq_enable_one = 1'b0; // cpu-side gate of the aggregate request
  int n_fail = 0, n_compared = 0;
  ufef_flags ufef_flags_i (.mclk(mclk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
    .avs_response(resp), .ctrl_rx_done(ev[0]), .ctrl_tx_done(ev[1]), .ep1_in_done(ev[2]),
    .ep1_out_done(ev[3]), .pkt_error(ev[4]), .sof_token(ev[5]), .sof_missed(ev[6]),
    .frame_number(fn), .bus_reset_sig(line[0]), .bus_resume_sig(line[1]),
    .bus_suspend_sig(line[2]), .usb_irq(irq), .sleeping(slp));
  ufef_host ufef_host_i (.mclk(mclk), .line_q(line));
  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge mclk); while (wt !== 1'b0);
    got = rdat;
    gresp = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(got, {24'h0, exp});
  endtask
  // one-cycle event strobe with a fresh frame number
  task pulse(input logic [6:0] e);
    @(posedge mclk);
    ev <= e;
    fn <= 11'($urandom);
    @(posedge mclk);
    ev <= 7'h00;
    @(negedge mclk);
  endtask
  function logic [7:0] in_exp(input logic [7:0] e);
    return e[4] ? 8'h00 : {6'h00, e[2], e[0] | e[1]};
  endfunction
  function logic [7:0] out_exp(input logic [7:0] e);
    return {6'h00, e[3] & !e[4], 1'b0};
  endfunction
  task end_sim;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    end_sim;
  end
  // main sequence
  initial begin
    void'($urandom(84807));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(6'h02, 8'h00);
    rchk(6'h04, 8'h00);
    rchk(6'h0D, 8'h00);
    bus(1'b1, 6'h02, 8'hFF);
    rchk(6'h02, 8'h00);
    bus(1'b0, 6'h05, 8'h00);
    check({30'h0, gresp}, 32'h2);
    $display("test reset done");
    // random endpoint completions, some corrupted
    repeat (20) begin
      v = 8'($urandom) & 8'h1F;
      pulse(v[6:0]);
      check(irq, |(in_exp(v) | out_exp(v)));
      rchk(6'h02, in_exp(v));
      rchk(6'h04, out_exp(v));
      rchk(6'h02, 8'h00);
    end
    $display("test endpoint done");
    // frame flag latches but stays masked until enabled
    pulse(7'h20);
    check(irq, 1'b0);
    rchk(6'h0D, {5'h00, fn[10:8]});
    rchk(6'h06, 8'h08);
    bus(1'b1, 6'h0B, 8'h0F);
    pulse(7'h40);
    check(irq, 1'b1);
    check(irq & ext_irq_enable_one, 1'b0);
    @(posedge mclk);
    ext_irq_enable_one <= 1'b1;
    @(negedge mclk);
    check(irq & ext_irq_enable_one, 1'b1);
    rchk(6'h06, 8'h08);
    $display("test frame done");
    // bus reset, suspend with detection on, then resume
    ufef_host_i.sig(0);
    rchk(6'h06, 8'h04);
    bus(1'b1, 6'h00, 8'h01);
    ufef_host_i.sig(2);
    check(slp, 1'b1);
    rchk(6'h06, 8'h01);
    ufef_host_i.sig(1);
    check(slp, 1'b0);
    rchk(6'h06, 8'h02);
    $display("test bus done");
    end_sim;
  end
endmodule // usb_function_event_flags_bench
